// ==== dlf_loop_filter.v ====
// second-order dpll loop filter with phase offset adder and axi4-lite registers
//
// Contract
// R1: second-order recursive filter, alpha, beta, gamma
// R2: filter updates once per 2^exponent clocks
// R3: beta, gamma programmed positive, applied negative
// R4: alpha is mantissa/2048 shifted up, down
// R5: beta, gamma magnitude mantissa times 2^-(exp+15)
// R6: software keeps coefficients inside stable range
// R7: constant offset added before the filter
// R8: offset 14-bit two's complement, sign-extended
// R9: software keeps offset within 12-bit range
// R10: tuning word follows filter output when closed
// R11: reset clears state; coefficients load at update
`timescale 1ns/10ps
`include "dlf_consts.vh"
module dlf_loop_filter #(
	parameter PW  = 24,               // phase sample width
	parameter TW  = 48,               // tuning word width
	parameter DVW = 16                // update divider width
) (
	input  wire          core_clk,    // 25 MHz clock
	input  wire          rst,         // sync reset, high
	input  wire          s_axi_awvalid, // write address valid
	output wire          s_axi_awready, // write address ready
	input  wire [7:0]    s_axi_awaddr,  // write byte address
	input  wire          s_axi_wvalid,  // write data valid
	output wire          s_axi_wready,  // write data ready
	input  wire [31:0]   s_axi_wdata,   // write data
	input  wire [3:0]    s_axi_wstrb,   // byte enables
	output reg           s_axi_bvalid,  // write response valid
	input  wire          s_axi_bready,  // write response ready
	output reg  [1:0]    s_axi_bresp,   // write response code
	input  wire          s_axi_arvalid, // read address valid
	output wire          s_axi_arready, // read address ready
	input  wire [7:0]    s_axi_araddr,  // read byte address
	output reg           s_axi_rvalid,  // read data valid
	input  wire          s_axi_rready,  // read data ready
	output reg  [31:0]   s_axi_rdata,   // read data
	output reg  [1:0]    s_axi_rresp,   // read response code
	input  wire          phaseValid,    // detector sample valid
	output wire          phaseReady,    // always ready
	input  wire [PW-1:0] phaseData,     // signed detector sample
	output wire          twValid,       // tuning word valid
	input  wire          twReady,       // synthesizer takes word
	output wire [TW-1:0] twData         // frequency_tuning_word
);
	localparam AW = 64;               // filter state width
	localparam MW = 96;               // product width

	// ----------------------------------------
	// shared arithmetic
	// ----------------------------------------
	// v * mant * 2^up * 2^-dn, arithmetic shifts keep the sign
	function signed [MW-1:0] scaleMul;
		input signed [MW-1:0] v;
		input [11:0]          mant;
		input [4:0]           up;
		input [4:0]           dn;
		reg signed [MW-1:0]   p;
		begin
			p = v * $signed({1'b0, mant});
			p = p <<< up;
			scaleMul = p >>> dn;
		end
	endfunction

	// byte-lane merge of a write into a register
	function [31:0] laneMerge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  st;
		integer      i;
		begin
			laneMerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (st[i])
					laneMerge[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction

	// ----------------------------------------
	// register file
	// ----------------------------------------
	reg  [31:0] ctrl_q;               // loop enable, p_divider_exponent
	reg  [31:0] alpha_q;              // alpha mantissa, up, down
	reg  [31:0] beta_q;               // beta magnitude fields
	reg  [31:0] gamma_q;              // gamma magnitude fields
	reg  [31:0] offset_q;             // phase offset, 14 bits
	reg  [AW-1:0] y1_q;               // filter output, previous update
	reg  [AW-1:0] y2_q;               // filter output, two back

	wire wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid; // both halves present
	wire rdTake = s_axi_arvalid & ~s_axi_rvalid;                // one read in flight
	assign s_axi_awready = wrTake;
	assign s_axi_wready  = wrTake;
	assign s_axi_arready = rdTake;

	wire [TW-1:0] twNow = y1_q[`DLF_FRAC +: TW]; // integer part of filter output

	// write channel: address and data taken together, response next cycle
	always @(posedge core_clk) begin
		if (rst) begin
			ctrl_q       <= `DLF_RST_CTRL;
			alpha_q      <= `DLF_RST_COEF;
			beta_q       <= `DLF_RST_COEF;
			gamma_q      <= `DLF_RST_COEF;
			offset_q     <= `DLF_RST_OFFSET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DLF_RESP_OK;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wrTake) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `DLF_RESP_OK;
				case (s_axi_awaddr)
					`DLF_OFF_CTRL:   ctrl_q   <= laneMerge(ctrl_q, s_axi_wdata, s_axi_wstrb);
					`DLF_OFF_ALPHA:  alpha_q  <= laneMerge(alpha_q, s_axi_wdata, s_axi_wstrb);
					`DLF_OFF_BETA:   beta_q   <= laneMerge(beta_q, s_axi_wdata, s_axi_wstrb);
					`DLF_OFF_GAMMA:  gamma_q  <= laneMerge(gamma_q, s_axi_wdata, s_axi_wstrb);
					`DLF_OFF_OFFSET: offset_q <= laneMerge(offset_q, s_axi_wdata, s_axi_wstrb);
					`DLF_OFF_TW_LO, `DLF_OFF_TW_HI: s_axi_bresp <= `DLF_RESP_OK; // read-only, write ignored
					default:         s_axi_bresp <= `DLF_RESP_DEC; // unmapped
				endcase
			end
		end
	end

	// read channel: data registered one cycle after the address is taken
	always @(posedge core_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `DLF_RESP_OK;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rdTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `DLF_RESP_OK;
				case (s_axi_araddr)
					`DLF_OFF_CTRL:   s_axi_rdata <= ctrl_q & 32'h0000_00f1;
					`DLF_OFF_ALPHA:  s_axi_rdata <= alpha_q & 32'h071f_0fff;
					`DLF_OFF_BETA:   s_axi_rdata <= beta_q & 32'h0007_0fff;
					`DLF_OFF_GAMMA:  s_axi_rdata <= gamma_q & 32'h0007_0fff;
					`DLF_OFF_OFFSET: s_axi_rdata <= offset_q & 32'h0000_3fff;
					`DLF_OFF_TW_LO:  s_axi_rdata <= twNow[31:0];
					`DLF_OFF_TW_HI:  s_axi_rdata <= {{(64-TW){1'b0}}, twNow[TW-1:32]};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `DLF_RESP_DEC;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// offset adder on the detector stream
	// ----------------------------------------
	reg  [PW-1:0] xIn_q;              // latest offset-corrected sample
	wire [PW-1:0] ofsExt = {{(PW-14){offset_q[`DLF_OFS_HI]}}, offset_q[`DLF_OFS_HI:0]}; // R8

	assign phaseReady = 1'b1;         // only the newest sample matters to the filter

	// every sample gets the constant added before it enters the filter
	always @(posedge core_clk) begin
		if (rst)
			xIn_q <= {PW{1'b0}};
		else if (phaseValid)
			xIn_q <= phaseData + ofsExt; // R7
	end

	// ----------------------------------------
	// update divider
	// ----------------------------------------
	reg  [DVW-1:0] divCnt_q;          // clocks since last tick
	reg            pend_q;            // tick waiting for buffer room
	reg            push_q;            // word written last update
	wire [3:0]     pExp = ctrl_q[`DLF_CTRL_PEXP_HI:`DLF_CTRL_PEXP_LO]; // p_divider_exponent
	wire           loopOn = ctrl_q[`DLF_CTRL_LOOP]; // closed loop
	wire [DVW-1:0] divLast = ({{(DVW-1){1'b0}}, 1'b1} << pExp) - {{(DVW-1){1'b0}}, 1'b1};
	wire           tick = (divCnt_q >= divLast); // one pulse each P clocks
	wire           bufReady;          // room in output buffer
	// a word still on its way in takes the last slot; at P=1 a stalled sink would otherwise lose it
	wire           inFlight = push_q & twValid & ~twReady; // buffer full once it lands
	wire           doUpd = (tick | pend_q) & bufReady & ~inFlight & loopOn; // stalls while buffer full

	// free divider; a tick held off by back-pressure is kept pending
	always @(posedge core_clk) begin
		if (rst) begin
			divCnt_q <= {DVW{1'b0}};
			pend_q   <= 1'b0;
		end else begin
			divCnt_q <= tick ? {DVW{1'b0}} : divCnt_q + {{(DVW-1){1'b0}}, 1'b1}; // R2
			if (doUpd || !loopOn)
				pend_q <= 1'b0;
			else if (tick)
				pend_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// coefficient shadows, loaded at update
	// ----------------------------------------
	reg [11:0] aMant_q;               // alpha mantissa
	reg [4:0]  aUp_q;                 // alpha up-shift
	reg [2:0]  aDn_q;                 // alpha down-shift
	reg [11:0] bMant_q;               // beta magnitude mantissa
	reg [2:0]  bExp_q;                // beta exponent
	reg [11:0] gMant_q;               // gamma magnitude mantissa
	reg [2:0]  gExp_q;                // gamma exponent

	// mid-period writes never mix old and new coefficients in one step
	always @(posedge core_clk) begin
		if (rst) begin
			aMant_q <= 12'h000;
			aUp_q   <= 5'h00;
			aDn_q   <= 3'h0;
			bMant_q <= 12'h000;
			bExp_q  <= 3'h0;
			gMant_q <= 12'h000;
			gExp_q  <= 3'h0;
		end else if (doUpd || !loopOn) begin // R11
			aMant_q <= alpha_q[`DLF_MANT_HI:0];
			aUp_q   <= alpha_q[`DLF_AUP_HI:`DLF_AUP_LO];
			aDn_q   <= alpha_q[`DLF_ADN_HI:`DLF_ADN_LO];
			bMant_q <= beta_q[`DLF_MANT_HI:0];
			bExp_q  <= beta_q[`DLF_EXP_HI:`DLF_EXP_LO];
			gMant_q <= gamma_q[`DLF_MANT_HI:0];
			gExp_q  <= gamma_q[`DLF_EXP_HI:`DLF_EXP_LO];
		end
	end

	// ----------------------------------------
	// recursive filter
	// ----------------------------------------
	// with B, G the programmed magnitudes (beta=-B, gamma=-G):
	// y[n] = y1 + (y1-y2) - G(y1-y2) + alpha*(x1 - x2 - (B-G)x2)
	reg  [PW-1:0] x1_q;               // sample used one update back
	reg  [PW-1:0] x2_q;               // sample used two updates back
	wire [4:0] bDn = `DLF_BG_DN + {2'h0, bExp_q};    // R5
	wire [4:0] gDn = `DLF_BG_DN + {2'h0, gExp_q};    // R5
	wire [4:0] aDn = `DLF_ALPHA_DN + {2'h0, aDn_q};  // R4
	wire signed [MW-1:0] x1F = $signed({{(MW-PW){x1_q[PW-1]}}, x1_q}) <<< `DLF_FRAC;
	wire signed [MW-1:0] x2F = $signed({{(MW-PW){x2_q[PW-1]}}, x2_q}) <<< `DLF_FRAC;
	wire signed [MW-1:0] y1F = $signed({{(MW-AW){y1_q[AW-1]}}, y1_q});
	wire signed [MW-1:0] y2F = $signed({{(MW-AW){y2_q[AW-1]}}, y2_q});
	wire signed [MW-1:0] dY  = y1F - y2F;
	// numerator zero at 1+B-G: B enters with its negative sign, G is added back
	wire signed [MW-1:0] vF  = x1F - x2F - scaleMul(x2F, bMant_q, 5'h00, bDn)
	                           + scaleMul(x2F, gMant_q, 5'h00, gDn);          // R3
	wire signed [MW-1:0] aT  = scaleMul(vF, aMant_q, aUp_q, aDn);             // R4
	wire signed [MW-1:0] yN  = y1F + dY - scaleMul(dY, gMant_q, 5'h00, gDn) + aT; // R1
	wire [AW-1:0] yNew = yN[AW-1:0];  // wraps like the phase accumulator it drives

	// state advances once per update; opening the loop clears it
	always @(posedge core_clk) begin
		if (rst || !loopOn) begin    // R11
			y1_q <= {AW{1'b0}};
			y2_q <= {AW{1'b0}};
			x1_q <= {PW{1'b0}};
			x2_q <= {PW{1'b0}};
		end else if (doUpd) begin
			y1_q <= yNew;                // R1
			y2_q <= y1_q;
			x1_q <= xIn_q;
			x2_q <= x1_q;
		end
	end

	// ----------------------------------------
	// tuning word out through the buffer
	// ----------------------------------------
	// pushed one cycle after the state moves so the buffer sees the new output
	always @(posedge core_clk) begin
		if (rst)
			push_q <= 1'b0;
		else
			push_q <= doUpd;
	end

	dlf_buf2 #(
		.W        (TW)
	) uOutBuf (
		.core_clk (core_clk),
		.rst      (rst),
		.inValid  (push_q),            // R10
		.inReady  (bufReady),
		.inData   (twNow),
		.outValid (twValid),
		.outReady (twReady),
		.outData  (twData)
	);
endmodule // dlf_loop_filter

// ==== dlf_consts.vh ====
// register map, field layout, reset values and fixed-point constants of the loop filter
`ifndef DLF_CONSTS_VH
`define DLF_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DLF_OFF_CTRL     8'h00
`define DLF_OFF_ALPHA    8'h04
`define DLF_OFF_BETA     8'h08
`define DLF_OFF_GAMMA    8'h0c
`define DLF_OFF_OFFSET   8'h10
`define DLF_OFF_TW_LO    8'h14
`define DLF_OFF_TW_HI    8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define DLF_CTRL_LOOP    0
`define DLF_CTRL_PEXP_LO 4
`define DLF_CTRL_PEXP_HI 7
`define DLF_MANT_HI      11
`define DLF_AUP_LO       16
`define DLF_AUP_HI       20
`define DLF_ADN_LO       24
`define DLF_ADN_HI       26
`define DLF_EXP_LO       16
`define DLF_EXP_HI       18
`define DLF_OFS_HI       13
// ----------------------------------------
// reset values
// ----------------------------------------
`define DLF_RST_CTRL     32'h0000_0000
`define DLF_RST_COEF     32'h0000_0000
`define DLF_RST_OFFSET   32'h0000_0000
// ----------------------------------------
// fixed point and scaling
// ----------------------------------------
`define DLF_FRAC         16
`define DLF_ALPHA_DN     5'h0b
`define DLF_BG_DN        5'h0f
`define DLF_RESP_OK      2'h0
`define DLF_RESP_DEC     2'h3
`endif

// ==== dlf_buf2.v ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module dlf_buf2 #(
	parameter W = 48                  // word width
) (
	input  wire         core_clk,     // clock
	input  wire         rst,          // sync reset, high
	input  wire         inValid,      // writer offers a word
	output wire         inReady,      // room for a word
	input  wire [W-1:0] inData,       // word in
	output wire         outValid,     // a word is held
	input  wire         outReady,     // reader takes it
	output wire [W-1:0] outData       // oldest word, from a flop
);
	reg [W-1:0] slot0_q;              // head entry
	reg [W-1:0] slot1_q;              // second entry
	reg [1:0]   count_q;              // entries held

	wire push = inValid & inReady;    // accepted write
	wire pop  = outValid & outReady;  // accepted read

	assign inReady  = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outData  = slot0_q;

	// ----------------------------------------
	// storage and occupancy
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			count_q <= 2'h0;
			slot0_q <= {W{1'b0}};
			slot1_q <= {W{1'b0}};
		end else begin
			// head advances on a read; a write lands behind whatever remains
			if (pop) begin
				slot0_q <= (count_q == 2'h2) ? slot1_q : inData;
				if (push && count_q == 2'h2)
					slot1_q <= inData;
			end else if (push) begin
				if (count_q == 2'h0)
					slot0_q <= inData;
				else
					slot1_q <= inData;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // dlf_buf2

// ==== dlf_far_model.sv ====
// far-side model: phase detector source and tuning word sink
`timescale 1ns/10ps
module dlf_far_model (
	input  wire        core_clk,   // clock
	input  wire        rst,        // sync reset, high
	input  wire        stall,      // bench asks the sink to stall
	input  wire [23:0] sample,     // detector level to send
	output reg         phaseValid, // sample qualifier
	output reg  [23:0] phaseData,  // detector sample
	input  wire        twValid,    // word offered
	output reg         twReady,    // sink ready
	input  wire [47:0] twData      // tuning word
);
	logic [47:0] wordLog [0:15];   // captured words, in order
	int          nWords = 0;       // words taken
	int          gap    = 0;       // cycles between the last two words
	int          cyc    = 0;       // free cycle count
	int          lastAt = 0;       // cycle of the last word
	initial begin
		phaseValid = 1'b0;
		phaseData  = 24'h0;
		twReady    = 1'b0;
	end
	// ----------------------------------------
	// source streams every cycle, sink takes unless stalled
	// ----------------------------------------
	// detector never pauses, so only the latest level matters
	always @(posedge core_clk) begin
		cyc        <= cyc + 1;
		phaseValid <= 1'b1;
		phaseData  <= sample;
		twReady    <= !stall;
		if (rst) begin
			nWords <= 0;
		end else if (twValid && twReady) begin
			wordLog[nWords[3:0]] <= twData;
			nWords <= nWords + 1;
			gap    <= cyc - lastAt;
			lastAt <= cyc;
		end
	end
endmodule // dlf_far_model

// ==== dlf_loop_filter_checker.sv ====
// concurrent checks on the loop filter ports
`timescale 1ns/10ps
module dlf_loop_filter_checker #(
	parameter TW = 48                  // tuning word width
) (
	input wire          core_clk,      // clock
	input wire          rst,           // sync reset
	input wire          s_axi_awvalid, // write address valid
	input wire          s_axi_awready, // write address ready
	input wire          s_axi_wvalid,  // write data valid
	input wire          s_axi_wready,  // write data ready
	input wire          s_axi_bvalid,  // write response valid
	input wire          s_axi_arvalid, // read address valid
	input wire          s_axi_arready, // read address ready
	input wire [7:0]    s_axi_araddr,  // read address
	input wire          s_axi_rvalid,  // read data valid
	input wire [31:0]   s_axi_rdata,   // read data
	input wire [1:0]    s_axi_rresp,   // read response
	input wire          phaseReady,    // sample ready
	input wire          twValid,       // word valid
	input wire          twReady,       // word ready
	input wire [TW-1:0] twData         // tuning word
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// request taking
	// ----------------------------------------
	sequence s_wr_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && !s_axi_rvalid;
	endsequence
	a_write_ready_term: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
		&& s_axi_wready == s_axi_awready) else $error("write ready term wrong");
	a_read_ready_term: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
		else $error("read ready term wrong");
	a_write_answer: assert property (s_wr_take |=> s_axi_bvalid) else $error("no write response");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("no read response");
	a_unmapped_decode: assert property (s_rd_take ##0 s_axi_araddr > 8'h18 |=> s_axi_rresp == 2'h3
		&& s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_mapped_okay: assert property (s_rd_take ##0 (s_axi_araddr <= 8'h18 && s_axi_araddr[1:0] == 2'h0)
		|=> s_axi_rresp == 2'h0) else $error("mapped read refused");
	// ----------------------------------------
	// tuning word stream
	// ----------------------------------------
	a_word_hold: assert property (twValid && !twReady |=> twValid && $stable(twData))
		else $error("word changed while stalled");
	a_reset_clear: assert property ($fell(rst) |-> !twValid && twData == '0 && !s_axi_bvalid)
		else $error("state not cleared by reset");
	a_phase_ready: assert property (phaseReady) else $error("sample refused");
endmodule // dlf_loop_filter_checker

// ==== dlf_loop_filter_tb.sv ====
// self-checking bench for the loop filter
`timescale 1ns/10ps
`include "dlf_consts.vh"
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module dlf_loop_filter_tb;
	logic        core_clk = 1'b0;  // 25 MHz clock
	logic        rst      = 1'b1;  // sync reset
	logic        awValid  = 1'b0;  // write request
	logic        wValid   = 1'b0;  // write data valid
	logic        bReady   = 1'b0;  // response ready
	logic        arValid  = 1'b0;  // read request
	logic        rReady   = 1'b0;  // read data ready
	logic [7:0]  awAddr   = 8'h0;  // write address
	logic [7:0]  arAddr   = 8'h0;  // read address
	logic [31:0] wData    = 32'h0; // write data
	logic [3:0]  wStrb    = 4'h0;  // byte enables
	logic        stall    = 1'b0;  // sink stall request
	logic [23:0] sample   = 24'h0; // detector level
	wire         awReady, wReady, bValid, arReady, rValid, phaseValid, phaseReady, twValid, twReady;
	wire [1:0]   bResp, rResp;     // response codes
	wire [31:0]  rData;            // read data
	wire [23:0]  phaseData;        // sample to the filter
	wire [47:0]  twData;           // tuning word
	int          failures  = 0;    // mismatches
	int          nCompared = 0;    // comparisons made
	logic [47:0] d2;               // second difference of words
	// case table: alpha, offset, detector level, divider exponent, step
	logic [31:0] alphaTab [0:3] = '{32'h0000_0800, 32'h0001_0800, 32'h0100_0800, 32'h0002_0400};
	logic [13:0] offTab [0:3]   = '{14'h0005, 14'h3ffb, 14'h0006, 14'h3800};
	logic [23:0] smpTab [0:3]   = '{24'h3, 24'h0, 24'h0, 24'h0};
	logic [3:0]  pexpTab [0:3]  = '{4'h3, 4'h2, 4'h4, 4'h5};
	logic [47:0] diffTab [0:3]  = '{48'h8, 48'hffff_ffff_fff6, 48'h3, 48'hffff_ffff_f000};
	logic [31:0] maskTab [1:4]  = '{32'h071f_0fff, 32'h0007_0fff, 32'h0007_0fff, 32'h0000_3fff};
	dlf_loop_filter dut (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .phaseValid(phaseValid),
		.phaseReady(phaseReady), .phaseData(phaseData), .twValid(twValid), .twReady(twReady), .twData(twData));
	dlf_far_model far (.core_clk(core_clk), .rst(rst), .stall(stall), .sample(sample), .phaseValid(phaseValid),
		.phaseData(phaseData), .twValid(twValid), .twReady(twReady), .twData(twData));
	initial forever #20 core_clk = ~core_clk;
	// ----------------------------------------
	// bus tasks: hold each channel until its ready edge
	// ----------------------------------------
	task automatic regWrite(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		int t;
		begin
			t = 0;
			awValid <= 1'b1;
			wValid  <= 1'b1;
			awAddr  <= a;
			wData   <= d;
			wStrb   <= s;
			bReady  <= 1'b1;
			do @(posedge core_clk); while (awReady !== 1'b1 && ++t < 200);
			awValid <= 1'b0;
			wValid  <= 1'b0;
			do @(posedge core_clk); while (bValid !== 1'b1 && ++t < 200);
			if (t >= 200) failures++; // bus wait ran out
			bReady  <= 1'b0;
			`CHK("bresp", er, bResp)
			@(posedge core_clk);
		end
	endtask
	task automatic regRead(input [7:0] a, input [31:0] ed, input [1:0] er);
		int t;
		begin
			t = 0;
			arValid <= 1'b1;
			arAddr  <= a;
			rReady  <= 1'b1;
			do @(posedge core_clk); while (arReady !== 1'b1 && ++t < 200);
			arValid <= 1'b0;
			do @(posedge core_clk); while (rValid !== 1'b1 && ++t < 200);
			if (t >= 200) failures++; // bus wait ran out
			rReady  <= 1'b0;
			`CHK("rdata", ed, rData)
			`CHK("rresp", er, rResp)
			@(posedge core_clk);
		end
	endtask
	// bounded wait on the sink's word count
	task automatic waitWords(input int n);
		int t;
		begin
			t = 0;
			while (far.nWords < n && t < 4000) begin
				@(posedge core_clk);
				t++;
			end
			if (t >= 4000) failures++; // words never came
		end
	endtask
	task automatic pulseReset;
		begin
			rst <= 1'b1;
			repeat (3) @(posedge core_clk);
			rst <= 1'b0;
			@(posedge core_clk);
			`CHK("word after reset", 48'h0, twData)
		end
	endtask
	task automatic tally_and_finish;
		begin
			$display("compared %0d mismatches %0d", nCompared, failures);
			if (failures == 0 && nCompared > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	// watchdog: the whole sequence needs well under this
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		tally_and_finish();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int a = 0; a < 7; a++) regRead(8'(a * 4), 32'h0, `DLF_RESP_OK);
		regRead(8'h1c, 32'h0, `DLF_RESP_DEC);
		regWrite(8'h20, 32'hffff_ffff, 4'hf, `DLF_RESP_DEC);
		for (int a = 1; a < 5; a++) begin
			regWrite(8'(a * 4), 32'hffff_ffff, 4'hf, `DLF_RESP_OK);
			regRead(8'(a * 4), maskTab[a], `DLF_RESP_OK);
		end
		regWrite(`DLF_OFF_OFFSET, 32'h0, 4'hf, `DLF_RESP_OK);
		regWrite(`DLF_OFF_OFFSET, 32'h0000_3fff, 4'h2, `DLF_RESP_OK);
		regRead(`DLF_OFF_OFFSET, 32'h0000_3f00, `DLF_RESP_OK);
		regWrite(`DLF_OFF_TW_LO, 32'hffff_ffff, 4'hf, `DLF_RESP_OK);
		regRead(`DLF_OFF_TW_LO, 32'h0, `DLF_RESP_OK);
		// ramp cases: a constant detector level makes the word step by alpha times the offset sample each update
		for (int i = 0; i < 4; i++) begin
			pulseReset();
			sample <= smpTab[i];
			regWrite(`DLF_OFF_ALPHA, alphaTab[i], 4'hf, `DLF_RESP_OK);
			regWrite(`DLF_OFF_OFFSET, {18'h0, offTab[i]}, 4'hf, `DLF_RESP_OK);
			repeat (40) @(posedge core_clk);
			`CHK("open loop words", 0, far.nWords)
			regWrite(`DLF_OFF_CTRL, {24'h0, pexpTab[i], 4'h1}, 4'hf, `DLF_RESP_OK);
			waitWords(3);
			stall <= 1'b1;
			repeat (60) @(posedge core_clk);
			`CHK("word held", 1'b1, twValid)
			stall <= 1'b0;
			waitWords(10);
			for (int k = 3; k < 9; k++) `CHK("word step", diffTab[i], far.wordLog[k+1] - far.wordLog[k])
			`CHK("update gap", 32'd1 << pexpTab[i], far.gap)
		end
		// beta alone bends the ramp downward by beta times the offset each update
		pulseReset();
		sample <= 24'h0;
		regWrite(`DLF_OFF_ALPHA, 32'h0000_0800, 4'hf, `DLF_RESP_OK);
		regWrite(`DLF_OFF_BETA, 32'h0000_0fff, 4'hf, `DLF_RESP_OK);
		regWrite(`DLF_OFF_OFFSET, 32'h0000_07ff, 4'hf, `DLF_RESP_OK);
		regWrite(`DLF_OFF_CTRL, 32'h0000_0021, 4'hf, `DLF_RESP_OK);
		waitWords(8);
		d2 = (far.wordLog[6] - far.wordLog[5]) - (far.wordLog[5] - far.wordLog[4]);
		`CHK("curvature", 1'b1, d2 === 48'hffff_ffff_ff00 || d2 === 48'hffff_ffff_ff01)
		tally_and_finish();
	end
endmodule // dlf_loop_filter_tb
bind dlf_loop_filter dlf_loop_filter_checker #(.TW(TW)) u_chk (.core_clk(core_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .phaseReady(phaseReady), .twValid(twValid),
	.twReady(twReady), .twData(twData));
